// >>> elr_map.vh
`ifndef ELR_MAP_VH
`define ELR_MAP_VH

// defect bitmap field positions (low bit of each two-bit field)
`define ELR_LOS_LSB        0
`define ELR_LOM_LSB        2
`define ELR_SEF_LSB        4

// two-bit field codes
`define ELR_CODE_START     2'h1
`define ELR_CODE_END       2'h2
`define ELR_CODE_NONE      2'h0

// width of every event record's data
`define ELR_DATA_W         8

// retransmission event identifiers
`define ELR_RETX_RSVD      8'h00
`define ELR_RETX_LEFTR     8'h01

// event type codes held in the buffer
`define ELR_TYPE_DEFECT    1'h0
`define ELR_TYPE_RETX      1'h1

// reset values
`define ELR_RST_MAP        8'h00
`define ELR_RST_DEFECTS    3'h0

// buffer defaults
`define ELR_DEF_DEPTH      8
`define ELR_DEF_CW         4
`define ELR_DEF_IW         3

`endif

// >>> elr_sync.v
`timescale 1ns/1ps
`default_nettype none

// three-stage pin synchroniser; the output follows only once the second
// and third stages agree, so a single metastable sample never passes
module elr_sync #(
	parameter W = 3
) (
	// clock and reset
	input  wire         i_clock,
	input  wire         i_rstn,
	// pins and result
	input  wire [W-1:0] i_pin,
	output wire [W-1:0] o_level
);

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1)
		begin : g_bit
			reg s1_r;
			reg s2_r;
			reg s3_r;
			reg lvl_r;
			always @(posedge i_clock or negedge i_rstn)
			begin
				if (!i_rstn)
				begin
					s1_r  <= 1'b0;
					s2_r  <= 1'b0;
					s3_r  <= 1'b0;
					lvl_r <= 1'b0;
				end
				else
				begin
					s1_r <= i_pin[g];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r)
						lvl_r <= s3_r;
				end
			end
			assign o_level[g] = lvl_r;
		end
	endgenerate

endmodule // elr_sync
`default_nettype wire

// >>> elr_defect.v
`timescale 1ns/1ps
`default_nettype none

`include "elr_map.vh"

// per-second defect tracker: builds the start/end bitmap at every tick
module elr_defect (
	// clock and reset
	input  wire       i_clock,
	input  wire       i_rstn,
	// one-second tick and synchronised defect levels {sef, lom, los}
	input  wire       i_sec_tick,
	input  wire [2:0] i_defect,
	// record out
	output reg        o_valid,
	output reg  [7:0] o_map
);

	reg  [2:0] seen_r;
	reg  [2:0] prev_r;
	wire [2:0] cur;
	wire [2:0] started;
	wire [2:0] ended;
	wire [7:0] map;

	// a defect seen in any cycle of the second marks the whole second
	assign cur     = seen_r | i_defect;
	assign started = cur & ~prev_r;
	assign ended   = prev_r & ~cur;
	// started and ended are disjoint per type by construction

	// one bitmap for all three types, bits 7:6 zero
	assign map = {2'h0,
		started[2] ? `ELR_CODE_START :
			(ended[2] ? `ELR_CODE_END : `ELR_CODE_NONE),
		started[1] ? `ELR_CODE_START :
			(ended[1] ? `ELR_CODE_END : `ELR_CODE_NONE),
		started[0] ? `ELR_CODE_START :
			(ended[0] ? `ELR_CODE_END : `ELR_CODE_NONE)};

	always @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			seen_r  <= `ELR_RST_DEFECTS;
			prev_r  <= `ELR_RST_DEFECTS;
			o_valid <= 1'b0;
			o_map   <= `ELR_RST_MAP;
		end
		else if (i_sec_tick)
		begin
			seen_r  <= `ELR_RST_DEFECTS;
			prev_r  <= cur;
			o_valid <= |(started | ended);
			o_map   <= map;
		end
		else
		begin
			seen_r  <= cur;
			o_valid <= 1'b0;
		end
	end

endmodule // elr_defect
`default_nettype wire

// >>> elr_top.v
`timescale 1ns/1ps
`default_nettype none

`include "elr_map.vh"

module elr_top #(
	parameter DEPTH = `ELR_DEF_DEPTH,
	parameter CW    = `ELR_DEF_CW,
	parameter IW    = `ELR_DEF_IW
) (
	// clock and reset
	input  wire                   i_clock,
	input  wire                   i_rstn,
	// timing and line defect pins
	input  wire                   i_sec_tick,
	input  wire                   i_los,
	input  wire                   i_lom,
	input  wire                   i_sef,
	// retransmission inputs
	input  wire                   i_office_side,
	input  wire                   i_retx_mode,
	input  wire                   i_leftr_us,
	input  wire                   i_leftr_ds,
	// configuration
	input  wire [CW-1:0]          i_depth_defect,
	input  wire [CW-1:0]          i_depth_retx,
	input  wire                   i_clear,
	// record read port
	input  wire [IW-1:0]          i_rd_idx,
	output reg                    o_rd_valid,
	output reg                    o_rd_type,
	output reg  [`ELR_DATA_W-1:0] o_rd_data,
	// status
	output reg  [CW-1:0]          o_fill,
	output reg  [CW-1:0]          o_cnt_defect,
	output reg  [CW-1:0]          o_cnt_retx,
	output reg                    o_full,
	output reg                    o_wr,
	output reg                    o_evict,
	output reg  [`ELR_DATA_W-1:0] o_last_map
);

	localparam [CW-1:0] CAP = DEPTH;
	localparam [CW-1:0] ONE = 1;

	wire [2:0]             defect_lvl;
	wire                   def_valid;
	wire [7:0]             def_map;

	reg                    pend_def_r;
	reg  [7:0]             pend_map_r;
	reg                    pend_retx_r;

	reg                    type_r [0:DEPTH-1];
	reg  [`ELR_DATA_W-1:0] data_r [0:DEPTH-1];
	reg                    type_nxt [0:DEPTH-1];
	reg  [`ELR_DATA_W-1:0] data_nxt [0:DEPTH-1];
	reg  [CW-1:0]          fill_r;
	reg  [CW-1:0]          cnt_def_r;
	reg  [CW-1:0]          cnt_retx_r;
	reg  [CW-1:0]          fill_nxt;
	reg  [CW-1:0]          cnt_def_nxt;
	reg  [CW-1:0]          cnt_retx_nxt;

	wire                   retx_hit;
	wire                   wr;
	wire                   wr_type;
	wire [`ELR_DATA_W-1:0] wr_data;
	wire                   full;
	wire                   over_def;
	wire                   over_retx;
	reg  [IW-1:0]          ev_idx;
	reg                    ev_type;
	reg                    evict;
	integer                j;

	elr_sync #(
		.W       (3)
	) u_sync (
		.i_clock (i_clock),
		.i_rstn  (i_rstn),
		.i_pin   ({i_sef, i_lom, i_los}),
		.o_level (defect_lvl)
	);

	elr_defect u_defect (
		.i_clock    (i_clock),
		.i_rstn     (i_rstn),
		.i_sec_tick (i_sec_tick),
		.i_defect   (defect_lvl),
		.o_valid    (def_valid),
		.o_map      (def_map)
	);

	// the low error-free-rate defect is near-end only, so each side logs
	// just the direction it receives
	assign retx_hit = i_retx_mode &
		(i_office_side ? i_leftr_us : i_leftr_ds);

	// one buffer write per cycle; defect wins, retransmission waits a cycle
	assign wr      = pend_def_r | pend_retx_r;
	assign wr_type = pend_def_r ? `ELR_TYPE_DEFECT : `ELR_TYPE_RETX;
	assign wr_data = pend_def_r ? pend_map_r : `ELR_RETX_LEFTR;

	assign full = (fill_r == CAP);

	// a type is a candidate if already above its depth, or if the
	// incoming record of that type would take it above
	assign over_def  = (wr_type == `ELR_TYPE_DEFECT) ?
		(cnt_def_r >= i_depth_defect) : (cnt_def_r > i_depth_defect);
	assign over_retx = (wr_type == `ELR_TYPE_RETX) ?
		(cnt_retx_r >= i_depth_retx) : (cnt_retx_r > i_depth_retx);

	// entry 0 is always the oldest, so the first candidate found is the
	// one to drop; a misconfigured host with no candidate loses entry 0
	always @*
	begin
		ev_idx = {IW{1'b0}};
		for (j = DEPTH - 1; j >= 0; j = j - 1)
		begin
			if ((type_r[j] == `ELR_TYPE_DEFECT) ? over_def : over_retx)
				ev_idx = j[IW-1:0];
		end
		ev_type = type_r[ev_idx];
		evict   = wr & full;
	end

	// entries stay packed oldest-first; eviction closes the gap and the
	// new record lands at the young end
	always @*
	begin
		for (j = 0; j < DEPTH; j = j + 1)
		begin
			type_nxt[j] = type_r[j];
			data_nxt[j] = data_r[j];
		end
		fill_nxt     = fill_r;
		cnt_def_nxt  = cnt_def_r;
		cnt_retx_nxt = cnt_retx_r;
		if (i_clear)
		begin
			fill_nxt     = {CW{1'b0}};
			cnt_def_nxt  = {CW{1'b0}};
			cnt_retx_nxt = {CW{1'b0}};
		end
		else if (wr)
		begin
			if (evict)
			begin
				for (j = 0; j < DEPTH - 1; j = j + 1)
				begin
					if (j >= ev_idx)
					begin
						type_nxt[j] = type_r[j+1];
						data_nxt[j] = data_r[j+1];
					end
				end
				type_nxt[DEPTH-1] = wr_type;
				data_nxt[DEPTH-1] = wr_data;
				if (ev_type == `ELR_TYPE_DEFECT)
					cnt_def_nxt = cnt_def_nxt - ONE;
				else
					cnt_retx_nxt = cnt_retx_nxt - ONE;
			end
			else
			begin
				for (j = 0; j < DEPTH; j = j + 1)
				begin
					if (j == fill_r)
					begin
						type_nxt[j] = wr_type;
						data_nxt[j] = wr_data;
					end
				end
				fill_nxt = fill_r + ONE;
			end
			if (wr_type == `ELR_TYPE_DEFECT)
				cnt_def_nxt = cnt_def_nxt + ONE;
			else
				cnt_retx_nxt = cnt_retx_nxt + ONE;
		end
	end

	// pending flags: a new event in the cycle its flag drains still wins
	always @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pend_def_r  <= 1'b0;
			pend_map_r  <= `ELR_RST_MAP;
			pend_retx_r <= 1'b0;
		end
		else
		begin
			pend_def_r  <= def_valid | (pend_def_r & i_clear);
			if (def_valid)
				pend_map_r <= def_map;
			pend_retx_r <= retx_hit |
				(pend_retx_r & (pend_def_r | i_clear));
		end
	end

	always @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			for (j = 0; j < DEPTH; j = j + 1)
			begin
				type_r[j] <= `ELR_TYPE_DEFECT;
				data_r[j] <= `ELR_RST_MAP;
			end
			fill_r     <= {CW{1'b0}};
			cnt_def_r  <= {CW{1'b0}};
			cnt_retx_r <= {CW{1'b0}};
		end
		else
		begin
			for (j = 0; j < DEPTH; j = j + 1)
			begin
				type_r[j] <= type_nxt[j];
				data_r[j] <= data_nxt[j];
			end
			fill_r     <= fill_nxt;
			cnt_def_r  <= cnt_def_nxt;
			cnt_retx_r <= cnt_retx_nxt;
		end
	end

	// read and count outputs are registered views of the state after this cycle's update; o_last_map follows the defect tracker directly
	always @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_rd_valid   <= 1'b0;
			o_rd_type    <= `ELR_TYPE_DEFECT;
			o_rd_data    <= `ELR_RST_MAP;
			o_fill       <= {CW{1'b0}};
			o_cnt_defect <= {CW{1'b0}};
			o_cnt_retx   <= {CW{1'b0}};
			o_full       <= 1'b0;
			o_wr         <= 1'b0;
			o_evict      <= 1'b0;
			o_last_map   <= `ELR_RST_MAP;
		end
		else
		begin
			o_rd_valid   <= ({1'b0, i_rd_idx} < {1'b0, fill_nxt});
			o_rd_type    <= type_nxt[i_rd_idx];
			o_rd_data    <= data_nxt[i_rd_idx];
			o_fill       <= fill_nxt;
			o_cnt_defect <= cnt_def_nxt;
			o_cnt_retx   <= cnt_retx_nxt;
			o_full       <= (fill_nxt == CAP);
			o_wr         <= wr & ~i_clear;
			o_evict      <= evict & ~i_clear;
			if (def_valid)
				o_last_map <= def_map;
		end
	end

endmodule // elr_top
`default_nettype wire

// >>> elr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module elr_checker #(
	parameter DEPTH = 8,
	parameter CW    = 4,
	parameter IW    = 3
) (
	// clock and reset
	input wire logic          i_clock,
	input wire logic          i_rstn,
	// causes
	input wire logic          i_sec_tick,
	input wire logic          i_retx_mode,
	// status
	input wire logic [CW-1:0] o_fill,
	input wire logic [CW-1:0] o_cnt_defect,
	input wire logic [CW-1:0] o_cnt_retx,
	input wire logic          o_full,
	input wire logic          o_wr,
	input wire logic          o_evict,
	input wire logic [7:0]    o_last_map
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	evict_with_write_a: assert property (o_evict |-> o_wr && o_full &&
		$past(o_full)) else $error("eviction outside a full write");
	append_step_a: assert property (o_wr && !o_evict |->
		o_fill == $past(o_fill) + 1'b1) else $error("append did not grow");
	full_evict_a: assert property ($past(o_full) && o_wr |-> o_evict)
		else $error("write to full buffer without eviction");
	full_flag_a: assert property (o_full == (o_fill == DEPTH))
		else $error("full flag wrong");
	count_sum_a: assert property (o_fill == o_cnt_defect + o_cnt_retx)
		else $error("type counts do not add up");
	map_fields_a: assert property (o_last_map[7:6] == 2'h0 &&
		o_last_map[1:0] != 2'h3 && o_last_map[3:2] != 2'h3 &&
		o_last_map[5:4] != 2'h3) else $error("bad bitmap field");
	retx_cause_a: assert property (o_cnt_retx > $past(o_cnt_retx) |->
		$past(i_retx_mode, 2) || $past(i_retx_mode, 4))
		else $error("retx record outside mode");
	defect_cause_a: assert property (o_cnt_defect > $past(o_cnt_defect) |->
		$past(i_sec_tick, 3) || $past(i_sec_tick, 4) ||
		$past(i_sec_tick, 5)) else $error("defect record without tick");
endmodule // elr_checker
bind elr_top elr_checker #(.DEPTH(DEPTH), .CW(CW), .IW(IW)) i_chk (
	.i_clock(i_clock), .i_rstn(i_rstn), .i_sec_tick(i_sec_tick),
	.i_retx_mode(i_retx_mode), .o_fill(o_fill), .o_cnt_defect(o_cnt_defect),
	.o_cnt_retx(o_cnt_retx), .o_full(o_full), .o_wr(o_wr),
	.o_evict(o_evict), .o_last_map(o_last_map));
`default_nettype wire

// >>> elr_host.sv
`timescale 1ns/1ps
`default_nettype none
// management host: two depth plans, both summing to the buffer size
module elr_host (
	// plan select
	input  wire logic       i_mix,
	// depths
	output logic      [3:0] o_depth_defect,
	output logic      [3:0] o_depth_retx
);
	assign o_depth_defect = i_mix ? 4'h2 : 4'h4;
	assign o_depth_retx   = 4'h8 - o_depth_defect;
endmodule // elr_host
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       i_clock = 0, i_rstn = 0, tick = 0, mix = 0;
	logic [2:0] pins = 0, idx = 0;
	logic       office = 1, mode = 0, us = 0, ds = 0;
	logic [3:0] dd, dr, fill, cd, cr;
	logic       rv, rt, full, wr, ev;
	logic [7:0] rd, map;
	int         err_count = 0, total_checks = 0;
	always #20 i_clock = ~i_clock;
	elr_host i_host (.i_mix(mix), .o_depth_defect(dd), .o_depth_retx(dr));
	elr_top i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_sec_tick(tick),
		.i_los(pins[0]), .i_lom(pins[1]), .i_sef(pins[2]),
		.i_office_side(office), .i_retx_mode(mode), .i_leftr_us(us),
		.i_leftr_ds(ds), .i_depth_defect(dd), .i_depth_retx(dr),
		.i_clear(1'b0), .i_rd_idx(idx), .o_rd_valid(rv), .o_rd_type(rt),
		.o_rd_data(rd), .o_fill(fill), .o_cnt_defect(cd), .o_cnt_retx(cr),
		.o_full(full), .o_wr(wr), .o_evict(ev), .o_last_map(map));
	task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// pins settle through the synchroniser before the second closes
	task sec(input logic [2:0] d, input logic [7:0] m, input logic [3:0] f);
		@(posedge i_clock) pins <= d;
		repeat (6) @(posedge i_clock);
		tick <= 1;
		@(posedge i_clock) tick <= 0;
		repeat (6) @(negedge i_clock);
		chk("map", map, m);
		chk("fill", {4'h0, fill}, {4'h0, f});
	endtask
	task hit(input logic u, input logic d, input logic [3:0] f);
		@(posedge i_clock) us <= u;
		ds <= d;
		@(posedge i_clock) us <= 0;
		ds <= 0;
		repeat (6) @(negedge i_clock);
		chk("fill", {4'h0, fill}, {4'h0, f});
	endtask
	task rdc(input logic [2:0] i, input logic t, input logic [7:0] v);
		@(posedge i_clock) idx <= i;
		repeat (2) @(negedge i_clock);
		chk("valid", {7'h0, rv}, 8'h01);
		chk("type", {7'h0, rt}, {7'h0, t});
		chk("data", rd, v);
	endtask
	initial
	begin
		repeat (6) @(posedge i_clock);
		i_rstn <= 1;
		@(negedge i_clock);
		chk("full", {7'h0, full}, 8'h00);
		sec(3'h1, 8'h01, 4'h1);
		@(posedge i_clock) pins[1] <= 1;
		repeat (8) @(posedge i_clock);
		sec(3'h1, 8'h04, 4'h2);
		// a pin dropped mid-second still marks that second as defected
		sec(3'h0, 8'h08, 4'h3);
		sec(3'h4, 8'h12, 4'h4);
		sec(3'h0, 8'h12, 4'h4);
		sec(3'h0, 8'h20, 4'h5);
		hit(1, 0, 4'h5);
		@(posedge i_clock) mode <= 1;
		hit(0, 1, 4'h5);
		hit(1, 0, 4'h6);
		rdc(3'h5, 1, 8'h01);
		@(posedge i_clock) office <= 0;
		hit(1, 0, 4'h6);
		hit(0, 1, 4'h7);
		hit(0, 1, 4'h8);
		chk("full", {7'h0, full}, 8'h01);
		hit(0, 1, 4'h8);
		rdc(3'h0, 0, 8'h04);
		chk("retx", {4'h0, cr}, 8'h04);
		hit(0, 1, 4'h8);
		rdc(3'h0, 0, 8'h04);
		rdc(3'h3, 0, 8'h20);
		@(posedge i_clock) mix <= 1;
		sec(3'h1, 8'h01, 4'h8);
		rdc(3'h0, 0, 8'h08);
		chk("defect", {4'h0, cd}, 8'h04);
		test_done;
	end
	initial
	begin
		repeat (3000) @(posedge i_clock);
		err_count++;
		test_done;
	end
endmodule // tb_top
`default_nettype wire
